/* include/plid_regs.vh */
// register map and field positions of the interrupt, mailbox and doorbell block
`ifndef PLID_REGS_VH
`define PLID_REGS_VH
// register word indices (byte address = 4 * index)
`define PLID_IDX_ICS      4'h0
`define PLID_IDX_ABT      4'h1
`define PLID_IDX_P2L      4'h2
`define PLID_IDX_L2P      4'h3
`define PLID_IDX_MBX0     4'h8
// control/status field positions
`define PLID_B_TEA_EN     0
`define PLID_B_SERR_MSK   1
`define PLID_B_MBX_EN     3
`define PLID_B_LPAR_MSK   6
`define PLID_B_LPAR_STS   7
`define PLID_B_PCI_EN     8
`define PLID_B_L2P_EN     9
`define PLID_B_ABT_EN     10
`define PLID_B_LIN_EN     11
`define PLID_B_RETRY_MSK  12
`define PLID_B_L2P_STS    13
`define PLID_B_LIN_STS    15
`define PLID_B_LOUT_EN    16
`define PLID_B_P2L_EN     17
`define PLID_B_P2L_STS    20
`define PLID_B_MA_STS     13
`define PLID_B_TA_STS     12
`define PLID_RETRY_LIMIT  9'h100
`define PLID_CTRL_WMASK   32'h0003_1FFB
`define PLID_RST_CTRL     32'h0000_0000
`endif

/* verilog/plid_access_arb.v */
// arbiter that keeps pci and local register accesses from racing
`default_nettype none
module plid_access_arb (
  input  wire clk_sys,
  input  wire arst_n,
  input  wire pci_req,
  input  wire loc_req,
  output wire pci_go,
  output wire pci_retry,
  output wire loc_go,
  output wire loc_hold
);
  reg owner_pci_reg;
  reg owner_loc_reg;
  reg owner_pci_next;
  reg owner_loc_next;

  always @* begin
    owner_pci_next = owner_pci_reg & pci_req;
    owner_loc_next = owner_loc_reg & loc_req;
    if (!owner_pci_next && !owner_loc_next) begin
      // pci wins a tie; local simply waits one access
      if (pci_req) begin
        owner_pci_next = 1'b1;
      end else if (loc_req) begin
        owner_loc_next = 1'b1;
      end
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      owner_pci_reg <= 1'b0;
      owner_loc_reg <= 1'b0;
    end else begin
      owner_pci_reg <= owner_pci_next;
      owner_loc_reg <= owner_loc_next;
    end
  end

  assign pci_go    = pci_req & owner_pci_next;
  assign pci_retry = pci_req & ~owner_pci_next;
  assign loc_go    = loc_req & owner_loc_next;
  assign loc_hold  = loc_req & ~owner_loc_next;
endmodule
`default_nettype wire

/* verilog/plid_irq_core.v */
// interrupt, abort capture, mailbox and doorbell logic of the bridge
`include "plid_regs.vh"
`default_nettype none
// Function
// - strap low makes pci interrupt pin an input; high drives it out.
// - pci interrupt is a level, dropping when enable or cause clears.
// - pci sources: doorbell, local input, aborts, dma, outbound post, 256 retries.
// - enabled local input asserts pci interrupt while held.
// - status bit 15 always mirrors the local interrupt input.
// - master enable bit 8 low holds pci interrupt off.
// - local output is a level from doorbell, mailbox, bist, dma, queue, pci, power.
// - split-ack mode adds abort, parity, overflow, serr; maskable except aborts.
// - bit 16 gates local output; it holds while enabled status stays set.
// - split-ack mode error ack always on; only retry cause maskable.
// - master/target abort sets word 4 bit 15/14; interrupts if bits 10 and 8 set.
// - abort latches master id in 26:24 and pci address capture.
// - eight 32-bit mailboxes readable and writable by both sides.
// - pci mailbox 0-3 write with bits 3 and 16 asserts local output.
// - pci mailbox 0-3 write sets status 31:28 when bit 3 set.
// - mailbox interrupt clears only after local reads every written mailbox.
// - local-to-pci bell: local one sets, pci one clears, zero nothing.
// - pci-to-local bell: pci one sets, local one clears, zero nothing.
// - any local-to-pci bell with bits 9,8 holds pci interrupt; bit 13 pending.
// - any pci-to-local bell with bits 17,16 holds local output; bit 20 pending.
// - pci access to registers withholds the local ready acknowledge.
// - local access to registers makes competing pci accesses retry.
module plid_irq_core #(
  parameter NUM_MBX   = 8,
  parameter RETRY_W   = 9
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        host_mode_strap_n,
  input  wire        pci_irq_in_n,
  output wire        pci_irq_out_n,
  output wire        pci_irq_oe_n,
  input  wire        local_irq_in_n,
  output reg         local_irq_out_n,
  input  wire        split_ack_mode,
  input  wire        pci_req,
  input  wire        pci_wr,
  input  wire [3:0]  pci_idx,
  input  wire [31:0] pci_wdata,
  output reg  [31:0] pci_rdata,
  output wire        pci_ack,
  output wire        pci_retry,
  input  wire        loc_req,
  input  wire        loc_wr,
  input  wire [3:0]  loc_idx,
  input  wire [31:0] loc_wdata,
  output reg  [31:0] loc_rdata,
  output wire        transfer_ack_n,
  output wire        transfer_error_ack_n,
  input  wire        master_abort_evt,
  input  wire        target_abort_evt,
  input  wire [2:0]  abort_master_id,
  input  wire [31:0] pci_cur_addr,
  input  wire        pci_retry_evt,
  input  wire        pci_xfer_ok,
  input  wire        dma_pci_irq,
  input  wire        dma_loc_irq,
  input  wire        outbound_post_ne,
  input  wire        inbound_post_ne,
  input  wire        bist_irq,
  input  wire        pm_change_irq,
  input  wire        det_parity_err,
  input  wire        local_parity_err,
  input  wire        outbound_free_ovf,
  input  wire        pci_serr_in
);
  reg  [31:0] ctrl_reg;
  reg  [31:0] abort_address_capture_reg;
  reg  [31:0] pci_to_local_bell_reg;
  reg  [31:0] local_to_pci_bell_reg;
  reg  [3:0]  mbx_pend_reg;
  reg         master_abort_reg;
  reg         target_abort_reg;
  reg  [2:0]  abort_id_reg;
  reg  [RETRY_W-1:0] retry_cnt_reg;
  reg         retry_abort_reg;
  reg         lpar_sts_reg;
  reg  [31:0] mbx_reg [0:NUM_MBX-1];
  wire        pci_go;
  wire        loc_go;
  wire        loc_hold;
  wire        pci_wr_go;
  wire        loc_wr_go;
  wire        loc_rd_go;
  wire        any_abort;
  wire        pci_cause;
  wire        loc_cause;
  wire        split_cause;
  wire        pci_irq_level;
  wire        mbx_wen_pci;
  wire        mbx_ren_loc;
  wire [31:0] status_word;
  wire        host_mode;
  reg         pci_ack_reg;

  plid_access_arb u_arb (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pci_req   (pci_req),
    .loc_req   (loc_req),
    .pci_go    (pci_go),
    .pci_retry (pci_retry),
    .loc_go    (loc_go),
    .loc_hold  (loc_hold)
  );

  assign pci_wr_go = pci_go & pci_wr;
  assign loc_wr_go = loc_go & loc_wr;
  assign loc_rd_go = loc_go & ~loc_wr;
  assign host_mode = host_mode_strap_n;
  assign any_abort = master_abort_reg | target_abort_reg;
  // mailboxes 0-3 sit at indices 8-11; only those raise or drop a pending flag
  assign mbx_wen_pci = pci_wr_go & pci_idx[3] & ~pci_idx[2];
  assign mbx_ren_loc = loc_rd_go & loc_idx[3] & ~loc_idx[2];

  // shared mailboxes, pci write wins a same-cycle clash
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MBX; gi = gi + 1) begin : g_mbx
      localparam integer MIDX_I = `PLID_IDX_MBX0 + gi;
      localparam [3:0]   MIDX   = MIDX_I[3:0];
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          mbx_reg[gi] <= 32'h0000_0000;
        end else if (pci_wr_go && pci_idx == MIDX) begin
          mbx_reg[gi] <= pci_wdata;
        end else if (loc_wr_go && loc_idx == MIDX) begin
          mbx_reg[gi] <= loc_wdata;
        end
      end
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mpend
      localparam integer PIDX_I = `PLID_IDX_MBX0 + gi;
      localparam [3:0]   PIDX   = PIDX_I[3:0];
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          mbx_pend_reg[gi] <= 1'b0;
        end else if (mbx_wen_pci && pci_idx == PIDX && ctrl_reg[`PLID_B_MBX_EN]) begin
          mbx_pend_reg[gi] <= 1'b1;
        end else if (mbx_ren_loc && loc_idx == PIDX) begin
          mbx_pend_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg                  <= `PLID_RST_CTRL;
      abort_address_capture_reg <= 32'h0000_0000;
      pci_to_local_bell_reg     <= 32'h0000_0000;
      local_to_pci_bell_reg     <= 32'h0000_0000;
      master_abort_reg          <= 1'b0;
      target_abort_reg          <= 1'b0;
      abort_id_reg              <= 3'h0;
      retry_cnt_reg             <= {RETRY_W{1'b0}};
      retry_abort_reg           <= 1'b0;
      lpar_sts_reg              <= 1'b0;
    end else begin
      // control bits: pci write wins over a local write in the same cycle
      if (pci_wr_go && pci_idx == `PLID_IDX_ICS) begin
        ctrl_reg <= pci_wdata & `PLID_CTRL_WMASK;
      end else if (loc_wr_go && loc_idx == `PLID_IDX_ICS) begin
        ctrl_reg <= loc_wdata & `PLID_CTRL_WMASK;
      end
      // local sets, pci clears; set wins
      local_to_pci_bell_reg <= (local_to_pci_bell_reg
        & ~((pci_wr_go && pci_idx == `PLID_IDX_L2P) ? pci_wdata : 32'h0000_0000))
        | ((loc_wr_go && loc_idx == `PLID_IDX_L2P) ? loc_wdata : 32'h0000_0000);
      // pci sets, local clears; set wins
      pci_to_local_bell_reg <= (pci_to_local_bell_reg
        & ~((loc_wr_go && loc_idx == `PLID_IDX_P2L) ? loc_wdata : 32'h0000_0000))
        | ((pci_wr_go && pci_idx == `PLID_IDX_P2L) ? pci_wdata : 32'h0000_0000);
      // abort status; clears by writing one, set wins
      master_abort_reg <= master_abort_evt | (master_abort_reg & ~(
        (pci_wr_go && pci_idx == `PLID_IDX_ICS && pci_wdata[`PLID_B_MA_STS + 16]) ||
        (loc_wr_go && loc_idx == `PLID_IDX_ICS && loc_wdata[`PLID_B_MA_STS + 16])));
      target_abort_reg <= target_abort_evt | (retry_cnt_reg == (`PLID_RETRY_LIMIT - 9'h001) && pci_retry_evt
        && ctrl_reg[`PLID_B_RETRY_MSK]) | (target_abort_reg & ~(
        (pci_wr_go && pci_idx == `PLID_IDX_ICS && pci_wdata[`PLID_B_TA_STS + 16]) ||
        (loc_wr_go && loc_idx == `PLID_IDX_ICS && loc_wdata[`PLID_B_TA_STS + 16])));
      // capture master id and address on abort
      if (master_abort_evt || target_abort_evt) begin
        abort_id_reg              <= abort_master_id;
        abort_address_capture_reg <= pci_cur_addr;
      end
      // consecutive retry counter, 256 in a row raises the retry cause
      if (pci_xfer_ok) begin
        retry_cnt_reg <= {RETRY_W{1'b0}};
      end else if (pci_retry_evt && retry_cnt_reg != `PLID_RETRY_LIMIT) begin
        retry_cnt_reg <= retry_cnt_reg + 1'b1;
      end
      retry_abort_reg <= (retry_cnt_reg == (`PLID_RETRY_LIMIT - 9'h001) && pci_retry_evt)
        | (retry_abort_reg & ~pci_xfer_ok);
      lpar_sts_reg <= local_parity_err | (lpar_sts_reg & ~(loc_wr_go && loc_idx == `PLID_IDX_ICS
        && loc_wdata[`PLID_B_LPAR_STS]));
    end
  end

  // status view; bits 31:28 show mailbox pending flags
  assign status_word = {mbx_pend_reg, 1'b0, abort_id_reg, 3'h0,
                        (|pci_to_local_bell_reg), 2'h0, ctrl_reg[17:16],
                        ~local_irq_in_n, 1'b0, (|local_to_pci_bell_reg & ctrl_reg[`PLID_B_L2P_EN]),
                        ctrl_reg[12:8], lpar_sts_reg, ctrl_reg[6:0]};

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pci_rdata   <= 32'h0000_0000;
      loc_rdata   <= 32'h0000_0000;
      pci_ack_reg <= 1'b0;
    end else begin
      pci_ack_reg <= pci_go;
      case (pci_idx)
        `PLID_IDX_ICS: pci_rdata <= status_word;
        `PLID_IDX_ABT: pci_rdata <= abort_address_capture_reg;
        `PLID_IDX_P2L: pci_rdata <= pci_to_local_bell_reg;
        `PLID_IDX_L2P: pci_rdata <= local_to_pci_bell_reg;
        4'h4:          pci_rdata <= {16'h0000, master_abort_reg, target_abort_reg, 14'h0000};
        default:       pci_rdata <= pci_idx[3] ? mbx_reg[pci_idx[2:0]] : 32'h0000_0000;
      endcase
      case (loc_idx)
        `PLID_IDX_ICS: loc_rdata <= status_word;
        `PLID_IDX_ABT: loc_rdata <= abort_address_capture_reg;
        `PLID_IDX_P2L: loc_rdata <= pci_to_local_bell_reg;
        `PLID_IDX_L2P: loc_rdata <= local_to_pci_bell_reg;
        4'h4:          loc_rdata <= {16'h0000, master_abort_reg, target_abort_reg, 14'h0000};
        default:       loc_rdata <= loc_idx[3] ? mbx_reg[loc_idx[2:0]] : 32'h0000_0000;
      endcase
    end
  end

  assign pci_ack = pci_ack_reg;
  // ready withheld while pci owns the registers
  assign transfer_ack_n = ~loc_go | loc_hold;

  assign pci_cause = (ctrl_reg[`PLID_B_L2P_EN] & (|local_to_pci_bell_reg))   // doorbell
                   | (ctrl_reg[`PLID_B_LIN_EN] & ~local_irq_in_n)            // local input
                   | (ctrl_reg[`PLID_B_ABT_EN] & any_abort)                  // aborts
                   | dma_pci_irq | outbound_post_ne | retry_abort_reg;
  assign pci_irq_level = ctrl_reg[`PLID_B_PCI_EN] & pci_cause;
  // drive only in host mode (strap high), open-drain style
  assign pci_irq_out_n = 1'b0;
  assign pci_irq_oe_n  = ~(host_mode & pci_irq_level);

  assign split_cause = split_ack_mode & (any_abort
                     | (det_parity_err & ctrl_reg[`PLID_B_RETRY_MSK])
                     | (lpar_sts_reg & ctrl_reg[`PLID_B_LPAR_MSK])
                     | (outbound_free_ovf & ctrl_reg[`PLID_B_TEA_EN])
                     | (pci_serr_in & ~host_mode & ctrl_reg[`PLID_B_SERR_MSK]));
  assign loc_cause = (ctrl_reg[`PLID_B_P2L_EN] & (|pci_to_local_bell_reg))
                   | (ctrl_reg[`PLID_B_MBX_EN] & (|mbx_pend_reg))
                   | bist_irq | dma_loc_irq | inbound_post_ne | pm_change_irq
                   | (~host_mode & ~pci_irq_in_n) | split_cause;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      local_irq_out_n <= 1'b1;
    end else begin
      // bit 16 gates the whole output
      local_irq_out_n <= ~(ctrl_reg[`PLID_B_LOUT_EN] & loc_cause);
    end
  end

  // error ack always on in split mode; only retry cause maskable
  assign transfer_error_ack_n = ~(split_ack_mode & loc_go & (master_abort_reg
                              | (target_abort_reg & ~(retry_abort_reg & ~ctrl_reg[`PLID_B_RETRY_MSK]))));
endmodule
`default_nettype wire

/* sim/plid_irq_core_chk.sv */
// assertion checker for the interrupt, mailbox and doorbell block
`default_nettype none
module plid_irq_core_chk (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        host_mode_strap_n,
  input wire logic        pci_irq_oe_n,
  input wire logic        local_irq_in_n,
  input wire logic        local_irq_out_n,
  input wire logic        split_ack_mode,
  input wire logic        pci_req,
  input wire logic        pci_wr,
  input wire logic [3:0]  pci_idx,
  input wire logic [31:0] pci_wdata,
  input wire logic        pci_ack,
  input wire logic        pci_retry,
  input wire logic        loc_req,
  input wire logic        loc_wr,
  input wire logic [3:0]  loc_idx,
  input wire logic [31:0] loc_wdata,
  input wire logic        transfer_ack_n,
  input wire logic        transfer_error_ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] en_reg;
  // enables 16, 11, 8 seen on completed control writes; pci writes lag the design by the ack cycle, local writes land on the same edge
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) en_reg <= 3'h0;
    else if (pci_ack && pci_wr && pci_idx == 4'h0) en_reg <= {pci_wdata[16], pci_wdata[11], pci_wdata[8]};
    else if (!transfer_ack_n && loc_wr && loc_idx == 4'h0) en_reg <= {loc_wdata[16], loc_wdata[11], loc_wdata[8]};
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  strap_pin_input_a: assert property (!host_mode_strap_n [*2] |-> pci_irq_oe_n)
    else $error("pci interrupt driven with strap low");
  local_in_raise_a: assert property (!local_irq_in_n && en_reg[1] && en_reg[0] && host_mode_strap_n && !pci_req
    |-> ##[0:3] !pci_irq_oe_n)
    else $error("local input did not raise pci interrupt");
  master_gate_a: assert property (!en_reg[0] && !pci_req |-> pci_irq_oe_n)
    else $error("pci interrupt with master enable low");
  local_out_gate_a: assert property (!en_reg[2] && !pci_req && !loc_req |=> local_irq_out_n)
    else $error("local output with output enable low");
  err_ack_cause_a: assert property (!transfer_error_ack_n |-> split_ack_mode && !transfer_ack_n)
    else $error("error ack outside split mode grant");
  pci_holdoff_a: assert property (!transfer_ack_n |-> !pci_ack)
    else $error("local and pci granted together");
  retry_on_local_a: assert property (pci_retry |-> loc_req && !pci_ack)
    else $error("retry without local access");
  reset_quiet_a: assert property ($rose(arst_n) |-> local_irq_out_n && pci_irq_oe_n)
    else $error("interrupt active after reset");
endmodule
bind plid_irq_core plid_irq_core_chk plid_irq_core_chk_inst (.clk_sys, .arst_n, .host_mode_strap_n,
  .pci_irq_oe_n, .local_irq_in_n, .local_irq_out_n, .split_ack_mode, .pci_req, .pci_wr, .pci_idx,
  .pci_wdata, .pci_ack, .pci_retry, .loc_req, .loc_wr, .loc_idx, .loc_wdata, .transfer_ack_n,
  .transfer_error_ack_n);
`default_nettype wire

/* sim/plid_far_model.sv */
// model of the far-side local device: interrupt line and abort reports
`default_nettype none
module plid_far_model #(
  parameter logic [31:0] ABT_ADDR = 32'h1234_5678
) (
  input  wire logic        clk_sys,
  input  wire logic        irq_req,
  input  wire logic [1:0]  abt_go,
  output var  logic        local_irq_in_n,
  output var  logic        master_abort_evt,
  output var  logic        target_abort_evt,
  output logic [2:0]       abort_master_id,
  output logic [31:0]      pci_cur_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    local_irq_in_n = 1'h1;
    master_abort_evt = 1'h0;
    target_abort_evt = 1'h0;
  end
  always @(posedge clk_sys) begin
    local_irq_in_n <= !irq_req;
    master_abort_evt <= abt_go[0];
    target_abort_evt <= abt_go[1];
  end
  // address valid only with event; scrambled otherwise so a late capture shows
  assign abort_master_id = (master_abort_evt || target_abort_evt) ? 3'h5 : 3'h2;
  assign pci_cur_addr = (master_abort_evt || target_abort_evt) ? ABT_ADDR : ~ABT_ADDR;
endmodule
`default_nettype wire

/* sim/plid_irq_core_bench.sv */
// self-checking bench for the interrupt, mailbox and doorbell block
`default_nettype none
module plid_irq_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CT = 32'h0003_0B08;
  localparam logic [31:0] AL = 32'h0003_1FFB;
  logic clk_sys = 0, arst_n = 0, host_mode_strap_n = 1, pci_irq_in_n = 1, split_ack_mode = 0, tea = 0;
  logic pci_req = 0, pci_wr = 0, loc_req = 0, loc_wr = 0, pci_retry_evt = 0, irq_req = 0, xfer_ok = 0;
  logic [3:0] pci_idx = 0, loc_idx = 0;
  logic [31:0] pci_wdata = 0, loc_wdata = 0, rd, pci_rdata, loc_rdata, pci_cur_addr;
  logic [1:0] abt_go = 0;
  logic [5:0] src = 0;
  logic [2:0] abort_master_id;
  logic pci_irq_out_n, pci_irq_oe_n, local_irq_out_n, pci_ack, pci_retry, transfer_ack_n, transfer_error_ack_n;
  logic local_irq_in_n, master_abort_evt, target_abort_evt;
  int err_total = 0, n_tests = 0, cyc = 0;
  plid_far_model plid_far_model_inst (.clk_sys, .irq_req, .abt_go, .local_irq_in_n, .master_abort_evt,
    .target_abort_evt, .abort_master_id, .pci_cur_addr);
  plid_irq_core plid_irq_core_inst (.clk_sys, .arst_n, .host_mode_strap_n, .pci_irq_in_n, .pci_irq_out_n,
    .pci_irq_oe_n, .local_irq_in_n, .local_irq_out_n, .split_ack_mode, .pci_req, .pci_wr, .pci_idx,
    .pci_wdata, .pci_rdata, .pci_ack, .pci_retry, .loc_req, .loc_wr, .loc_idx, .loc_wdata, .loc_rdata,
    .transfer_ack_n, .transfer_error_ack_n, .master_abort_evt, .target_abort_evt, .abort_master_id,
    .pci_cur_addr, .pci_retry_evt, .pci_xfer_ok(xfer_ok), .dma_pci_irq(src[0]), .dma_loc_irq(src[2]),
    .outbound_post_ne(src[1]), .inbound_post_ne(src[3]), .bist_irq(src[4]), .pm_change_irq(src[5]),
    .det_parity_err(1'h0), .local_parity_err(1'h0), .outbound_free_ovf(1'h0), .pci_serr_in(1'h0));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ceiling well above the several hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // request held until the edge that samples the ack
  task automatic pa(input logic w, input logic [3:0] i, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    pci_req <= 1'h1;
    pci_wr <= w;
    pci_idx <= i;
    pci_wdata <= d;
    @(posedge clk_sys);
    for (n = 0; n < 60 && pci_ack !== 1'h1; n++) @(posedge clk_sys);
    rd = pci_rdata;
    pci_req <= 1'h0;
    chk("pci ack", 1, pci_ack);
  endtask
  task automatic la(input logic w, input logic [3:0] i, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    loc_req <= 1'h1;
    loc_wr <= w;
    loc_idx <= i;
    loc_wdata <= d;
    @(posedge clk_sys);
    for (n = 0; n < 60 && transfer_ack_n !== 1'h0; n++) @(posedge clk_sys);
    if (transfer_error_ack_n === 1'h0) tea = 1'h1;
    loc_req <= 1'h0;
    chk("local ack", 0, transfer_ack_n);
    @(posedge clk_sys);
    rd = loc_rdata;
  endtask
  task automatic pw(input logic [3:0] i, input logic [31:0] d);
    pa(1'h1, i, d);
  endtask
  task automatic pr(input logic [3:0] i, input logic [31:0] e);
    pa(1'h0, i, 32'h0);
    chk("pci read", e, rd);
  endtask
  task automatic lr(input logic [3:0] i, input logic [31:0] e);
    la(1'h0, i, 32'h0);
    chk("local read", e, rd);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'h1;
    pr(4'h0, 32'h0);
    chk("pci irq", 1, pci_irq_oe_n);
    chk("local irq", 1, local_irq_out_n);
    chk("pci pin", 0, pci_irq_out_n);
    $display("reset test done");
    pw(4'h0, CT);
    pr(4'h0, CT);
    irq_req <= 1'h1;
    wt(4);
    pr(4'h0, CT | 32'h8000);
    chk("pci irq", 0, pci_irq_oe_n);
    pw(4'h0, CT & ~32'h900);
    wt(2);
    chk("pci irq", 1, pci_irq_oe_n);
    pr(4'h0, (CT & ~32'h900) | 32'h8000);
    pw(4'h0, CT);
    host_mode_strap_n <= 1'h0;
    pci_irq_in_n <= 1'h0;
    wt(4);
    chk("pci irq", 1, pci_irq_oe_n);
    chk("local irq", 0, local_irq_out_n);
    host_mode_strap_n <= 1'h1;
    pci_irq_in_n <= 1'h1;
    irq_req <= 1'h0;
    wt(4);
    chk("pci irq", 1, pci_irq_oe_n);
    $display("local input test done");
    la(1'h1, 4'h3, 32'hA5);
    la(1'h1, 4'h3, 32'h0);
    pr(4'h3, 32'hA5);
    pr(4'h0, CT | 32'h2000);
    chk("pci irq", 0, pci_irq_oe_n);
    pw(4'h3, 32'h05);
    pr(4'h3, 32'hA0);
    pw(4'h3, 32'hA0);
    wt(2);
    chk("pci irq", 1, pci_irq_oe_n);
    pw(4'h2, 32'h0F);
    wt(2);
    chk("local irq", 0, local_irq_out_n);
    pr(4'h0, CT | 32'h0010_0000);
    la(1'h1, 4'h2, 32'h03);
    lr(4'h2, 32'h0C);
    la(1'h1, 4'h2, 32'h0C);
    wt(2);
    chk("local irq", 1, local_irq_out_n);
    $display("doorbell test done");
    pw(4'h8, 32'hC0DE_0000);
    pw(4'hA, 32'hC0DE_0002);
    wt(2);
    chk("local irq", 0, local_irq_out_n);
    pr(4'h0, CT | 32'h5000_0000);
    lr(4'h8, 32'hC0DE_0000);
    chk("local irq", 0, local_irq_out_n);
    lr(4'hA, 32'hC0DE_0002);
    wt(2);
    chk("local irq", 1, local_irq_out_n);
    for (int i = 11; i < 16; i++) begin
      la(1'h1, i[3:0], 32'hBEEF_0000 + i);
      pr(i[3:0], 32'hBEEF_0000 + i);
    end
    fork
      la(1'h1, 4'h9, 32'h55);
      begin
        @(posedge clk_sys);
        pr(4'h9, 32'h55);
      end
    join
    // one side keeps its request up while the other asks
    @(posedge clk_sys);
    loc_wr <= 1'h0;
    loc_req <= 1'h1;
    @(posedge clk_sys);
    pci_wr <= 1'h0;
    pci_req <= 1'h1;
    @(posedge clk_sys);
    chk("pci retry", 1, pci_retry);
    loc_req <= 1'h0;
    @(posedge clk_sys);
    loc_req <= 1'h1;
    @(posedge clk_sys);
    chk("local held", 1, transfer_ack_n);
    pci_req <= 1'h0;
    loc_req <= 1'h0;
    wt(2);
    $display("mailbox test done");
    pw(4'h0, AL);
    for (int i = 0; i < 6; i++) begin
      src <= 6'h1 << i;
      wt(4);
      chk("source on", 0, i < 2 ? pci_irq_oe_n : local_irq_out_n);
      src <= 6'h0;
      wt(4);
      chk("source off", 1, i < 2 ? pci_irq_oe_n : local_irq_out_n);
    end
    $display("source test done");
    split_ack_mode <= 1'h1;
    abt_go <= 2'h1;
    @(posedge clk_sys);
    abt_go <= 2'h0;
    wt(3);
    chk("pci irq", 0, pci_irq_oe_n);
    pr(4'h1, 32'h1234_5678);
    pa(1'h0, 4'h0, 32'h0);
    chk("abort id", 3'h5, rd[26:24]);
    la(1'h0, 4'h0, 32'h0);
    chk("error ack", 1, tea);
    pw(4'h0, AL | 32'h3000_0000);
    wt(2);
    chk("pci irq", 1, pci_irq_oe_n);
    pci_retry_evt <= 1'h1;
    wt(100);
    pci_retry_evt <= 1'h0;
    xfer_ok <= 1'h1;
    @(posedge clk_sys);
    xfer_ok <= 1'h0;
    pci_retry_evt <= 1'h1;
    repeat (255) @(posedge clk_sys);
    chk("pci irq", 1, pci_irq_oe_n);
    @(posedge clk_sys);
    pci_retry_evt <= 1'h0;
    wt(3);
    chk("pci irq", 0, pci_irq_oe_n);
    pw(4'h0, AL | 32'h3000_0000);
    $display("abort test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
